// *** src/rhmc_button.sv ***
// Debounce and press classifier for one pushbutton.
// Assumes the raw button level is synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none

module rhmc_button
  import rhmc_pkg::*;
#(
  parameter int unsigned DEB_CYC  = DEBOUNCE_CYC,
  parameter int unsigned HOLD_LEN = HOLD_CYC
)
(
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic raw_btn,
  output logic      press_pulse,
  output logic      tap_pulse,
  output logic      hold_pulse,
  output logic      held
);

  localparam int unsigned DW = $clog2(DEB_CYC + 1);
  localparam int unsigned HW = $clog2(HOLD_LEN + 1);

  logic [DW-1:0] deb_cnt_reg;
  logic          stable_reg;
  logic [HW-1:0] hold_cnt_reg;
  logic          hold_done_reg;

  // ****************************************************************
  // Debounce: level must stay changed for DEB_CYC cycles
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      deb_cnt_reg <= '0;
      stable_reg  <= 1'b0;
    end
    else if (raw_btn == stable_reg)
      deb_cnt_reg <= '0;
    else if (deb_cnt_reg == DW'(DEB_CYC - 1))
    begin
      deb_cnt_reg <= '0;
      stable_reg  <= raw_btn;
    end
    else
      deb_cnt_reg <= deb_cnt_reg + 1'b1;
  end

  // Hold timer runs while the clean level is pressed
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      hold_cnt_reg  <= '0;
      hold_done_reg <= 1'b0;
    end
    else if (!stable_reg)
    begin
      hold_cnt_reg  <= '0;
      hold_done_reg <= 1'b0;
    end
    else if (!hold_done_reg)
    begin
      if (hold_cnt_reg == HW'(HOLD_LEN - 1))
        hold_done_reg <= 1'b1;
      hold_cnt_reg <= hold_cnt_reg + 1'b1;
    end
  end

  logic stable_d_reg;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      stable_d_reg <= 1'b0;
    else
      stable_d_reg <= stable_reg;
  end

  // Release before the threshold is a tap; reaching it is a hold
  assign press_pulse = stable_reg & ~stable_d_reg;
  assign tap_pulse   = ~stable_reg & stable_d_reg & ~hold_done_reg;
  assign hold_pulse  = stable_reg & ~hold_done_reg & (hold_cnt_reg == HW'(HOLD_LEN - 1));
  assign held        = stable_reg;

endmodule : rhmc_button

`default_nettype wire

// *** src/rhmc_pkg.sv ***
// Constants, modes and timing for the ride height mode controller.
// Assumes a single 25 MHz core clock; all times become cycle counts here.
package rhmc_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned HOLD_MS         = 3000;   // Hold threshold
  localparam int unsigned REAR_MAX_S      = 40;     // Rear raise limit
  localparam int unsigned STEADY_S        = 15;     // Normal lamp steady time
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned BLINK_MS        = 250;    // Half period of blink
  localparam int unsigned HOLD_CYC        = CLK_HZ / 1000 * HOLD_MS;
  localparam int unsigned REAR_MAX_CYC    = CLK_HZ * REAR_MAX_S;
  localparam int unsigned STEADY_CYC      = CLK_HZ * STEADY_S;
  localparam int unsigned DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
  localparam int unsigned BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;

  // ****************************************************************
  // Speed limits in MPH
  // ****************************************************************
  localparam logic [7:0] REAR_RAISE_MPH   = 8'h14;  // 20
  localparam logic [7:0] FULL_RAISE_MPH   = 8'h0a;  // 10
  localparam logic [7:0] PART_LOWER_MPH   = 8'h0a;  // 10
  localparam logic [7:0] FULL_LOWER_MPH   = 8'h05;  // 5
  localparam logic [7:0] LEVEL_FIND_MPH   = 8'h05;  // 5

  // ****************************************************************
  // Modes, Gray coded along raise/lower path
  // ****************************************************************
  typedef enum logic [2:0] {
    RHMC_NORMAL     = 3'h0,
    RHMC_REAR_RAISE = 3'h1,
    RHMC_FULL_RAISE = 3'h3,
    RHMC_PART_LOWER = 3'h2,
    RHMC_FULL_LOWER = 3'h6,
    RHMC_LEVEL_FIND = 3'h4
  } rhmc_mode_t;

  // Lamp drive codes
  typedef enum logic [1:0] {
    RHMC_LAMP_OFF    = 2'h0,
    RHMC_LAMP_BLINK  = 2'h1,
    RHMC_LAMP_STEADY = 2'h3
  } rhmc_lamp_t;

  // Arrow result codes
  typedef enum logic [1:0] {
    RHMC_ARROW_NEAR     = 2'h0,
    RHMC_ARROW_ADJUST   = 2'h1,
    RHMC_ARROW_MARGINAL = 2'h3,
    RHMC_ARROW_EXCESS   = 2'h2
  } rhmc_arrow_t;

  localparam logic [1:0] BTN_NONE = 2'h0;

endpackage : rhmc_pkg

// *** src/rhmc_top.sv ***
// Ride height mode controller: button decode, mode selection, lamps.
// Assumes synchronous button, speed and sensor inputs and a 25 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module rhmc_top
  import rhmc_pkg::*;
#(
  parameter int unsigned HOLD_LEN   = HOLD_CYC,
  parameter int unsigned REAR_LEN   = REAR_MAX_CYC,
  parameter int unsigned STEADY_LEN = STEADY_CYC,
  parameter int unsigned BLINK_LEN  = BLINK_CYC,
  parameter int unsigned DEB_LEN    = DEBOUNCE_CYC,
  parameter int unsigned SW         = 12,          // Sensor width
  parameter logic [SW-1:0] NEAR_LIM = 12'h010,     // Slope class bounds
  parameter logic [SW-1:0] ADJ_LIM  = 12'h080,
  parameter logic [SW-1:0] MARG_LIM = 12'h100
)
(
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  input  wire logic              raise_button,
  input  wire logic              lower_button,
  input  wire logic              normal_height_button,
  input  wire logic              level_button,
  input  wire logic              aux_normal_req,    // Auxiliary forced return
  input  wire logic [7:0]        speed_mph,
  input  wire logic              at_normal_height,  // All corners at ride height
  input  wire logic [4*SW-1:0]   corner_height,     // Signed offsets per corner
  input  wire logic [2*SW-1:0]   incline,           // X then Y, signed
  input  wire logic              hyd_active,
  input  wire logic [7:0]        hyd_valves,
  output logic      [7:0]        air_valves,        // Fill/exhaust per corner
  output logic      [2:0]        height_cmd,        // Commanded mode target
  output logic                   raise_lamp,
  output logic                   lower_lamp,
  output logic                   normal_lamp,
  output logic      [1:0]        arrow_green,       // X, Y
  output logic      [1:0]        arrow_amber
);

  localparam int unsigned RW = $clog2(REAR_LEN + 1);
  localparam int unsigned TW = $clog2(STEADY_LEN + 1);
  localparam int unsigned BW = $clog2(BLINK_LEN + 1);

  // ****************************************************************
  // Button decode
  // ****************************************************************
  logic [3:0] raw_vec;
  logic [3:0] tap_vec;
  logic [3:0] hold_vec;
  logic [3:0] press_vec;
  assign raw_vec = {level_button, normal_height_button, lower_button, raise_button};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_btn
      rhmc_button #(
        .DEB_CYC  (DEB_LEN),
        .HOLD_LEN (HOLD_LEN)
      ) u_btn (
        .core_clk    (core_clk),
        .sys_rst     (sys_rst),
        .raw_btn     (raw_vec[gi]),
        .press_pulse (press_vec[gi]),
        .tap_pulse   (tap_vec[gi]),
        .hold_pulse  (hold_vec[gi]),
        .held        ()
      );
    end
  endgenerate

  logic raise_tap, lower_tap, raise_hold, lower_hold, normal_press, level_press;
  assign raise_tap    = tap_vec[0];
  assign lower_tap    = tap_vec[1];
  assign raise_hold   = hold_vec[0];
  assign lower_hold   = hold_vec[1];
  assign normal_press = press_vec[2];
  assign level_press  = press_vec[3];

  // ****************************************************************
  // Mode state
  // ****************************************************************
  rhmc_mode_t    mode_reg, mode_next;
  logic [RW-1:0] rear_cnt_reg;
  logic          rear_expired;
  logic          returning_reg;    // Normal requested, not yet at height
  logic          ret_req;

  assign rear_expired = (rear_cnt_reg == RW'(REAR_LEN));

  // Next mode; taps act on release so a hold never triggers both variants
  always_comb
  begin
    mode_next = mode_reg;
    ret_req   = 1'b0;
    case (mode_reg)
      RHMC_NORMAL:
      begin
        if (raise_hold && speed_mph <= FULL_RAISE_MPH)
          mode_next = RHMC_FULL_RAISE;
        else if (raise_tap && speed_mph <= REAR_RAISE_MPH)
          mode_next = RHMC_REAR_RAISE;
        else if (lower_hold && speed_mph <= FULL_LOWER_MPH)
          mode_next = RHMC_FULL_LOWER;
        else if (lower_tap && speed_mph <= PART_LOWER_MPH)
          mode_next = RHMC_PART_LOWER;
        else if (level_press && speed_mph <= LEVEL_FIND_MPH)
          mode_next = RHMC_LEVEL_FIND;
        // Over-speed button actions fall through unchanged
      end
      RHMC_REAR_RAISE:
      begin
        if (raise_hold && speed_mph <= FULL_RAISE_MPH)
          mode_next = RHMC_FULL_RAISE;
        else if (speed_mph > REAR_RAISE_MPH || rear_expired || lower_tap)
        begin
          mode_next = RHMC_NORMAL;
          ret_req   = 1'b1;
        end
      end
      RHMC_FULL_RAISE:
      begin
        if (speed_mph > FULL_RAISE_MPH || lower_tap)
        begin
          mode_next = RHMC_NORMAL;
          ret_req   = 1'b1;
        end
      end
      RHMC_PART_LOWER:
      begin
        if (lower_hold && speed_mph <= FULL_LOWER_MPH)
          mode_next = RHMC_FULL_LOWER;
        else if (speed_mph > PART_LOWER_MPH || raise_tap)
        begin
          mode_next = RHMC_NORMAL;
          ret_req   = 1'b1;
        end
      end
      RHMC_FULL_LOWER:
      begin
        if (speed_mph > FULL_LOWER_MPH || raise_tap)
        begin
          mode_next = RHMC_NORMAL;
          ret_req   = 1'b1;
        end
      end
      RHMC_LEVEL_FIND:
      begin
        if (level_press)
        begin
          mode_next = RHMC_NORMAL;
          ret_req   = 1'b1;
        end
      end
      default:
        mode_next = RHMC_NORMAL;
    endcase
    // Normal button or auxiliary return wins over everything
    if (normal_press || aux_normal_req)
    begin
      mode_next = RHMC_NORMAL;
      ret_req   = 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      mode_reg <= RHMC_NORMAL;
    else
      mode_reg <= mode_next;
  end

  // Rear raise time limit; restarts on each entry
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || mode_reg != RHMC_REAR_RAISE)
      rear_cnt_reg <= '0;
    else if (!rear_expired)
      rear_cnt_reg <= rear_cnt_reg + 1'b1;
  end

  // ****************************************************************
  // Normal lamp sequencing
  // ****************************************************************
  logic [TW-1:0] steady_cnt_reg;
  logic          steady_on_reg;
  logic          lamp_req_reg;    // Normal pressed or auxiliary request, in any mode

  // Reset counts as power-up: start returning so the lamp flashes or holds
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      returning_reg <= 1'b1;
    else if (ret_req)
      returning_reg <= 1'b1;
    else if (mode_reg == RHMC_NORMAL && at_normal_height)
      returning_reg <= 1'b0;
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      steady_on_reg  <= 1'b0;
      steady_cnt_reg <= '0;
    end
    else if (mode_reg != RHMC_NORMAL || ret_req)
    begin
      steady_on_reg  <= 1'b0;
      steady_cnt_reg <= '0;
    end
    else if (returning_reg && at_normal_height)
    begin
      steady_on_reg  <= 1'b1;
      steady_cnt_reg <= '0;
    end
    else if (steady_on_reg)
    begin
      if (steady_cnt_reg == TW'(STEADY_LEN - 1))
        steady_on_reg <= 1'b0;
      steady_cnt_reg <= steady_cnt_reg + 1'b1;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      lamp_req_reg <= 1'b0;
    else
      lamp_req_reg <= normal_press | aux_normal_req;
  end

  // ****************************************************************
  // Blink timebase and lamp outputs
  // ****************************************************************
  logic [BW-1:0] blink_cnt_reg;
  logic          blink_reg;
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      blink_cnt_reg <= '0;
      blink_reg     <= 1'b0;
    end
    else if (blink_cnt_reg == BW'(BLINK_LEN - 1))
    begin
      blink_cnt_reg <= '0;
      blink_reg     <= ~blink_reg;
    end
    else
      blink_cnt_reg <= blink_cnt_reg + 1'b1;
  end

  // Lamps are registered; off in any mode not owning them
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      raise_lamp  <= 1'b0;
      lower_lamp  <= 1'b0;
      normal_lamp <= 1'b0;
    end
    else
    begin
      raise_lamp  <= (mode_reg == RHMC_FULL_RAISE) |
                     ((mode_reg == RHMC_REAR_RAISE) & blink_reg);
      lower_lamp  <= (mode_reg == RHMC_FULL_LOWER) |
                     ((mode_reg == RHMC_PART_LOWER) & blink_reg);
      normal_lamp <= (mode_reg == RHMC_NORMAL) &
                     (steady_on_reg | lamp_req_reg |
                      (returning_reg & blink_reg));
    end
  end

  // ****************************************************************
  // Level-find evaluation per axis
  // ****************************************************************
  logic [SW-1:0] corner_spread_reg;
  rhmc_arrow_t   arrow_class [2];

  // Corner spread is the XOR of the four offsets; its sign bit drops adjust to marginal
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      corner_spread_reg <= '0;
    else
      corner_spread_reg <= corner_height[SW-1:0] ^ corner_height[SW +: SW] ^
                           corner_height[2*SW +: SW] ^ corner_height[3*SW +: SW];
  end

  generate
    for (gi = 0; gi < 2; gi++)
    begin : g_axis
      logic [SW-1:0] tilt;
      logic [SW-1:0] mag_reg;
      assign tilt = incline[gi*SW +: SW];
      always_ff @(posedge core_clk)
      begin
        if (sys_rst)
          mag_reg <= '0;
        else
          mag_reg <= tilt[SW-1] ? SW'(-tilt) : tilt;
      end
      always_comb
      begin
        if (mag_reg <= NEAR_LIM)
          arrow_class[gi] = RHMC_ARROW_NEAR;
        else if (mag_reg <= ADJ_LIM && corner_spread_reg[SW-1] == 1'b0)
          arrow_class[gi] = RHMC_ARROW_ADJUST;
        else if (mag_reg <= MARG_LIM)
          arrow_class[gi] = RHMC_ARROW_MARGINAL;
        else
          arrow_class[gi] = RHMC_ARROW_EXCESS;
      end
      // Arrows dark outside level-find
      always_ff @(posedge core_clk)
      begin
        if (sys_rst || mode_reg != RHMC_LEVEL_FIND)
        begin
          arrow_green[gi] <= 1'b0;
          arrow_amber[gi] <= 1'b0;
        end
        else
        begin
          arrow_green[gi] <= (arrow_class[gi] == RHMC_ARROW_NEAR) |
                             ((arrow_class[gi] == RHMC_ARROW_ADJUST) & blink_reg);
          arrow_amber[gi] <= (arrow_class[gi] == RHMC_ARROW_EXCESS) |
                             ((arrow_class[gi] == RHMC_ARROW_MARGINAL) & blink_reg);
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Actuation commands
  // ****************************************************************
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      air_valves <= 8'h00;
      height_cmd <= 3'h0;
    end
    else
    begin
      height_cmd <= mode_reg;
      // Hydraulic leveling takes the valves outright
      air_valves <= hyd_active ? hyd_valves : 8'h00;
    end
  end

endmodule : rhmc_top

`default_nettype wire

// *** verif/rhmc_panel_model.sv ***
// Operator panel and ride height model.
// Assumes one-cycle go pulses from the bench.
`timescale 1ns/10ps
`default_nettype none

module rhmc_panel_model
  import rhmc_pkg::*;
#(
  parameter int unsigned SETTLE = 30
)
(
  input  wire logic       core_clk,
  input  wire logic       go,
  input  wire logic [2:0] btn_sel,
  input  wire logic [7:0] press_len,
  input  wire logic [2:0] height_cmd,
  output logic            raise_button,
  output logic            lower_button,
  output logic            normal_height_button,
  output logic            level_button,
  output logic            at_normal_height
);
  logic [7:0]  press_reg  = 8'h00;
  logic [2:0]  sel_reg    = 3'h0;
  int unsigned settle_reg = 0;

  // One press of press_len cycles
  always_ff @(posedge core_clk)
  begin
    if (go)
    begin
      press_reg <= press_len;
      sel_reg   <= btn_sel;
    end
    else if (press_reg != 8'h00)
      press_reg <= press_reg - 8'h01;
  end

  assign {level_button, normal_height_button, lower_button, raise_button} =
    {4{press_reg != 8'h00}} & (4'h1 << (sel_reg - 3'h1));

  // Settles only while normal is the target
  always_ff @(posedge core_clk)
  begin
    if (height_cmd !== RHMC_NORMAL)
      settle_reg <= 0;
    else if (settle_reg < SETTLE)
      settle_reg <= settle_reg + 1;
  end

  assign at_normal_height = settle_reg == SETTLE;
endmodule // rhmc_panel_model
`default_nettype wire

// *** verif/rhmc_top_props.sv ***
// Port-level checks for the ride height mode controller.
// Assumes a bind into rhmc_top.
`timescale 1ns/10ps
`default_nettype none

module rhmc_top_props
  import rhmc_pkg::*;
#(
  parameter int unsigned REAR_LEN = REAR_MAX_CYC
)
(
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic [7:0] speed_mph,
  input wire logic       hyd_active,
  input wire logic [7:0] hyd_valves,
  input wire logic [7:0] air_valves,
  input wire logic [2:0] height_cmd,
  input wire logic       raise_lamp,
  input wire logic       lower_lamp,
  input wire logic       normal_lamp,
  input wire logic [1:0] arrow_green,
  input wire logic [1:0] arrow_amber
);
  // ********
  // Helpers
  // ********
  default clocking dcb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  int unsigned rear_cnt_reg;

  // Cycles spent in rear raise
  always_ff @(posedge core_clk)
  begin
    if (sys_rst || height_cmd != RHMC_REAR_RAISE)
      rear_cnt_reg <= 0;
    else
      rear_cnt_reg <= rear_cnt_reg + 1;
  end

  // ********
  // Checks
  // ********
  // Not masked by default disable
  reset_clears_a: assert property (disable iff (1'b0) sys_rst |=> height_cmd == 3'h0 &&
      air_valves == 8'h00 && !raise_lamp && !lower_lamp && !normal_lamp &&
      arrow_green == 2'h0 && arrow_amber == 2'h0)
    else $error("outputs not reset");
  hyd_override_a: assert property (
      air_valves == ($past(hyd_active) ? $past(hyd_valves) : 8'h00))
    else $error("air valve override wrong");
  raise_lamp_mode_a: assert property (raise_lamp |->
      height_cmd == RHMC_REAR_RAISE || height_cmd == RHMC_FULL_RAISE)
    else $error("raise lamp outside raise");
  lower_lamp_mode_a: assert property (lower_lamp |->
      height_cmd == RHMC_PART_LOWER || height_cmd == RHMC_FULL_LOWER)
    else $error("lower lamp outside lower");
  full_lamp_steady_a: assert property ((height_cmd == RHMC_FULL_RAISE |-> raise_lamp)
      and (height_cmd == RHMC_FULL_LOWER |-> lower_lamp))
    else $error("full mode lamp not steady");
  rear_speed_exit_a: assert property (height_cmd == RHMC_REAR_RAISE &&
      speed_mph > REAR_RAISE_MPH |-> ##[1:3] height_cmd != RHMC_REAR_RAISE)
    else $error("rear raise over speed");
  full_raise_exit_a: assert property (height_cmd == RHMC_FULL_RAISE &&
      speed_mph > FULL_RAISE_MPH |-> ##[1:3] height_cmd != RHMC_FULL_RAISE)
    else $error("full raise over speed");
  part_lower_exit_a: assert property (height_cmd == RHMC_PART_LOWER &&
      speed_mph > PART_LOWER_MPH |-> ##[1:3] height_cmd != RHMC_PART_LOWER)
    else $error("partial lower over speed");
  full_lower_exit_a: assert property (height_cmd == RHMC_FULL_LOWER &&
      speed_mph > FULL_LOWER_MPH |-> ##[1:3] height_cmd != RHMC_FULL_LOWER)
    else $error("full lower over speed");
  rear_time_limit_a: assert property (rear_cnt_reg <= REAR_LEN + 3)
    else $error("rear raise too long");
  arrow_mode_a: assert property (arrow_green != 2'h0 || arrow_amber != 2'h0 |->
      height_cmd == RHMC_LEVEL_FIND)
    else $error("arrows outside level find");

  cover property (height_cmd == RHMC_FULL_RAISE);
  cover property (height_cmd == RHMC_FULL_LOWER);
  cover property (height_cmd == RHMC_LEVEL_FIND && arrow_amber != 2'h0);
endmodule // rhmc_top_props
`default_nettype wire

// *** verif/rhmc_top_tb.sv ***
// Self-checking bench for the ride height mode controller.
// Assumes shortened counts and the panel model.
`timescale 1ns/10ps
`default_nettype none

module rhmc_top_tb
  import rhmc_pkg::*;
;
  // ********
  // Setup
  // ********
  localparam int unsigned STEADY_L = 50;
  localparam int unsigned REAR_L   = 100;
  localparam int unsigned LIMIT    = 20000;
  localparam int unsigned SETTLE_W = 12;
  localparam logic [7:0]  TAP      = 8'h06;
  localparam logic [7:0]  HOLD     = 8'h1e;
  localparam logic [2:0]  B0 = 3'h0, BR = 3'h1, BL = 3'h2, BN = 3'h3, BV = 3'h4;
  localparam rhmc_lamp_t  LO = RHMC_LAMP_OFF, LB = RHMC_LAMP_BLINK, LS = RHMC_LAMP_STEADY;

  typedef struct {
    logic [2:0] b1;
    logic [7:0] l1;
    logic [7:0] s1;
    logic [2:0] b2;
    logic [7:0] s2;
    logic [2:0] cmd;
    rhmc_lamp_t rl;
    rhmc_lamp_t ll;
  } rhmc_row_t;

  // Action, tap, then expected mode and lamps
  rhmc_row_t rows [20] = '{
    '{BR, TAP, 8'h14, B0, 8'h14, 3'h1, LB, LO},
    '{BR, TAP, 8'h15, B0, 8'h15, 3'h0, LO, LO},
    '{BR, HOLD, 8'h0a, B0, 8'h0a, 3'h3, LS, LO},
    '{BR, HOLD, 8'h0b, B0, 8'h0b, 3'h0, LO, LO},
    '{BL, TAP, 8'h0a, B0, 8'h0a, 3'h2, LO, LB},
    '{BL, TAP, 8'h0b, B0, 8'h0b, 3'h0, LO, LO},
    '{BL, HOLD, 8'h05, B0, 8'h05, 3'h6, LO, LS},
    '{BL, HOLD, 8'h06, B0, 8'h06, 3'h0, LO, LO},
    '{BV, TAP, 8'h05, B0, 8'h05, 3'h4, LO, LO},
    '{BV, TAP, 8'h06, B0, 8'h06, 3'h0, LO, LO},
    '{BR, TAP, 8'h00, BL, 8'h00, 3'h0, LO, LO},
    '{BR, TAP, 8'h00, B0, 8'h15, 3'h0, LO, LO},
    '{BR, HOLD, 8'h00, BL, 8'h00, 3'h0, LO, LO},
    '{BR, HOLD, 8'h00, B0, 8'h0b, 3'h0, LO, LO},
    '{BL, TAP, 8'h00, BR, 8'h00, 3'h0, LO, LO},
    '{BL, TAP, 8'h00, B0, 8'h0b, 3'h0, LO, LO},
    '{BL, HOLD, 8'h00, BR, 8'h00, 3'h0, LO, LO},
    '{BL, HOLD, 8'h00, B0, 8'h06, 3'h0, LO, LO},
    '{BV, TAP, 8'h00, BN, 8'h00, 3'h0, LO, LO},
    '{BL, HOLD, 8'h00, BN, 8'h00, 3'h0, LO, LO}
  };
  logic [11:0] tilt  [4] = '{12'h000, 12'h040, 12'h0c0, 12'h200};
  rhmc_lamp_t  exp_g [4] = '{LS, LB, LO, LO};
  rhmc_lamp_t  exp_a [4] = '{LO, LO, LB, LS};

  logic        core_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        go = 1'b0;
  logic [2:0]  btn_sel = 3'h0;
  logic [7:0]  press_len = 8'h00;
  logic        aux_normal_req = 1'b0;
  logic [7:0]  speed_mph = 8'h00;
  logic [23:0] incline = 24'h000000;
  logic        hyd_active = 1'b0;
  logic [7:0]  hyd_valves = 8'h00;
  logic        raise_button, lower_button, normal_height_button, level_button;
  logic        at_normal_height, raise_lamp, lower_lamp, normal_lamp;
  logic [7:0]  air_valves;
  logic [2:0]  height_cmd;
  logic [1:0]  arrow_green, arrow_amber;
  rhmc_lamp_t  cr, cl, cg, ca;
  int          n_errors = 0;
  int          checks_done = 0;
  int          cycle_count = 0;

  always #20 core_clk = ~core_clk;

  rhmc_top #(.HOLD_LEN(20), .REAR_LEN(REAR_L), .STEADY_LEN(STEADY_L), .BLINK_LEN(4),
    .DEB_LEN(2)) i_rhmc_top (.core_clk(core_clk), .sys_rst(sys_rst),
    .raise_button(raise_button), .lower_button(lower_button),
    .normal_height_button(normal_height_button), .level_button(level_button),
    .aux_normal_req(aux_normal_req), .speed_mph(speed_mph),
    .at_normal_height(at_normal_height), .corner_height(48'h0), .incline(incline),
    .hyd_active(hyd_active), .hyd_valves(hyd_valves), .air_valves(air_valves),
    .height_cmd(height_cmd), .raise_lamp(raise_lamp), .lower_lamp(lower_lamp),
    .normal_lamp(normal_lamp), .arrow_green(arrow_green), .arrow_amber(arrow_amber));

  rhmc_panel_model i_rhmc_panel_model (.core_clk(core_clk), .go(go), .btn_sel(btn_sel),
    .press_len(press_len), .height_cmd(height_cmd), .raise_button(raise_button),
    .lower_button(lower_button), .normal_height_button(normal_height_button),
    .level_button(level_button), .at_normal_height(at_normal_height));

  // ********
  // Tasks
  // ********
  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input logic ok, input string what);
    checks_done++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask

  // Set speed, press one button, let decode settle
  task automatic act(input logic [2:0] b, input logic [7:0] len, input logic [7:0] s);
    @(posedge core_clk);
    speed_mph <= s;
    btn_sel   <= b;
    press_len <= len;
    go        <= (b != B0);
    @(posedge core_clk);
    go <= 1'b0;
    repeat (int'(len) + SETTLE_W) @(posedge core_clk);
  endtask

  function automatic rhmc_lamp_t cls(input int n);
    return (n == 0) ? LO : (n == 16) ? LS : LB;
  endfunction

  // Sixteen cycles span two blink periods
  task automatic sample16();
    int nr = 0, nl = 0, ng = 0, na = 0;
    repeat (16)
    begin
      @(posedge core_clk);
      #1;
      nr += int'(raise_lamp === 1'b1);
      nl += int'(lower_lamp === 1'b1);
      ng += int'(arrow_green[0] === 1'b1);
      na += int'(arrow_amber[0] === 1'b1);
    end
    cr = cls(nr);
    cl = cls(nl);
    cg = cls(ng);
    ca = cls(na);
  endtask

  // Flash off height, steady near STEADY_L, then dark
  task automatic watch_normal(input logic flash, input string what);
    int   tog = 0, hi = 0;
    logic last;
    last = normal_lamp;
    for (int k = 0; k < 200 && at_normal_height !== 1'b1; k++)
    begin
      @(posedge core_clk);
      #1;
      tog += int'(normal_lamp !== last);
      last = normal_lamp;
    end
    repeat (STEADY_L + 20)
    begin
      @(posedge core_clk);
      #1;
      hi += int'(normal_lamp === 1'b1);
    end
    check((tog > 1) == flash && hi >= STEADY_L - 4 && hi <= STEADY_L + 4 &&
      normal_lamp === 1'b0, what);
    $display("test %s done", what);
  endtask

  always @(posedge core_clk)
  begin
    cycle_count++;
    if (cycle_count == LIMIT)
    begin
      check(1'b0, "run did not finish");
      end_of_test();
    end
  end

  // ********
  // Sequence
  // ********
  initial
  begin
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    watch_normal(1'b1, "power-up off height");
    for (int i = 0; i < 20; i++)
    begin
      act(BN, TAP, 8'h00);
      act(rows[i].b1, rows[i].l1, rows[i].s1);
      act(rows[i].b2, TAP, rows[i].s2);
      sample16();
      check(height_cmd === rows[i].cmd && cr === rows[i].rl && cl === rows[i].ll, "row");
      $display("test row %0d done", i);
    end
    act(BR, TAP, 8'h00);
    repeat (REAR_L - 20) @(posedge core_clk);
    #1;
    check(height_cmd === 3'h1, "rear raise left early");
    repeat (30) @(posedge core_clk);
    #1;
    check(height_cmd === 3'h0 && raise_lamp === 1'b0, "rear raise timeout");
    act(BR, TAP, 8'h00);
    aux_normal_req <= 1'b1;
    @(posedge core_clk);
    aux_normal_req <= 1'b0;
    watch_normal(1'b1, "auxiliary return");
    check(height_cmd === 3'h0, "auxiliary return mode");
    hyd_active <= 1'b1;
    hyd_valves <= 8'h5a;
    repeat (3) @(posedge core_clk);
    check(air_valves === 8'h5a, "hydraulic override");
    hyd_active <= 1'b0;
    repeat (3) @(posedge core_clk);
    check(air_valves === 8'h00, "hydraulic release");
    act(BV, TAP, 8'h00);
    for (int j = 0; j < 4; j++)
    begin
      incline <= {12'h000, tilt[j]};
      repeat (4) @(posedge core_clk);
      sample16();
      check(cg === exp_g[j] && ca === exp_a[j] && arrow_green[1] && !arrow_amber[1],
        "arrow class");
    end
    act(BN, TAP, 8'h00);
    #1;
    check(arrow_green === 2'h0 && arrow_amber === 2'h0, "arrows after exit");
    repeat (STEADY_L + 40) @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    watch_normal(1'b0, "power-up at height");
    end_of_test();
  end
endmodule // rhmc_top_tb

bind rhmc_top rhmc_top_props #(.REAR_LEN(REAR_LEN)) i_rhmc_top_props (.core_clk(core_clk),
  .sys_rst(sys_rst), .speed_mph(speed_mph), .hyd_active(hyd_active),
  .hyd_valves(hyd_valves), .air_valves(air_valves), .height_cmd(height_cmd),
  .raise_lamp(raise_lamp), .lower_lamp(lower_lamp), .normal_lamp(normal_lamp),
  .arrow_green(arrow_green), .arrow_amber(arrow_amber));
`default_nettype wire
